// >>> design/sldc_pkg.sv
`default_nettype none
package sldc_pkg;
    // data memory bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 4;
    // display memory window, 48 words of 4 bits
    localparam logic [7:0] DISP_FIRST = 8'h80;
    localparam logic [7:0] DISP_LAST  = 8'hAF;
    localparam int         DISP_WORDS = 48;
    // control register offset and fields
    localparam logic [7:0] CTRL_ADDR   = 8'hDE;
    localparam int         DUTY_HI_BIT = 3;
    localparam int         DUTY_LO_BIT = 2;
    localparam int         ENABLE_BIT  = 0;
    localparam logic [1:0] DUTY_RESET  = 2'h0;
    localparam logic       ENABLE_RESET = 1'b0;
    // panel geometry
    localparam int SEG_N = 32;
    localparam int COM_N = 4;
    // common scan timing: each common slot lasts this long
    localparam int COM_SLOT_US   = 2000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int COM_SLOT_CYC  = COM_SLOT_US * 1000 / CLK_PERIOD_NS;
    // multiplex duty codes
    typedef enum logic [1:0] {
        SLDC_DUTY4 = 2'b00,
        SLDC_DUTY3 = 2'b01,
        SLDC_DUTY2 = 2'b10,
        SLDC_DUTY1 = 2'b11
    } sldc_duty_t;
endpackage
`default_nettype wire

// >>> design/sldc_top.sv
// Function
// R1: 192 bits of display memory as 48 four-bit words at data addresses 80H to AFH.
// R2: display memory is write-only; reads of it return no stored data.
// R3: a stored one lights its mapped segment, a zero leaves it dark.
// R4: duty field 00/01/10/11 selects 1/4, 1/3, 1/2, 1/1 dynamic drive.
// R5: with 32 segments, 4/3/2/1 commons use 128/96/64/32 memory bits.
// R6: memory bits not mapped under the current duty never reach the panel.
// R7: a build-time map assigns memory bits to segment and common positions.
// R8: display enable high shows the display; low forces every segment off.
// R9: reset clears both duty bits and the enable bit (1/4 duty, display off).
// R10: the unused control bit ignores writes and reads as zero.
// R11: software must write all display memory before enabling the display.
// R12: display memory and control are decoded with no page selection.
// R13: active commons are scanned in turn at a fixed rate, segments per common.
`timescale 1ns/1ns
`default_nettype none
module sldc_top
    import sldc_pkg::*;
#(
    parameter int SLOT_CYC = COM_SLOT_CYC,
    // build-time map: entry s*4+c holds the memory bit index (0..191) for seg s, com c
    parameter logic [SEG_N*COM_N*8-1:0] SEG_MAP = '0
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // data memory bus
    input  wire logic [ADDR_W-1:0] bus_addr,
    input  wire logic [DATA_W-1:0] bus_wdata,
    input  wire logic              bus_wr,
    input  wire logic              bus_rd,
    output logic      [DATA_W-1:0] bus_rdata,
    // panel drive
    output logic      [COM_N-1:0]  com_active,
    output logic      [SEG_N-1:0]  seg_lit,
    output logic                   display_on
);
    // elaboration check: a zero-length slot would never advance the scan
    if (SLOT_CYC < 1) begin : g_bad_slot
        $error("slot length must be at least one cycle");
    end

    ////////////////////////////////////////////////////////////////////////
    // bus decode, page bits are not part of the address
    // R12: direct decode
    logic disp_hit;
    logic ctrl_hit;
    assign disp_hit = (bus_addr >= DISP_FIRST) && (bus_addr <= DISP_LAST);
    assign ctrl_hit = (bus_addr == CTRL_ADDR);

    ////////////////////////////////////////////////////////////////////////
    // display memory, not reset on purpose (software fills it first)
    logic [DATA_W-1:0] disp_mem [DISP_WORDS];
    logic [5:0]        disp_idx;
    assign disp_idx = 6'(bus_addr - DISP_FIRST);

    // R1: word write into display memory
    always_ff @(posedge ref_clk) begin
        if (bus_wr && disp_hit) begin
            disp_mem[disp_idx] <= bus_wdata;
        end
    end

    // flat view for the segment map
    logic [DISP_WORDS*DATA_W-1:0] disp_flat;
    genvar w;
    generate
        for (w = 0; w < DISP_WORDS; w++) begin : g_flat
            assign disp_flat[w*DATA_W +: DATA_W] = disp_mem[w];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // control register
    logic [1:0] duty_sel;
    logic       display_enable;
    logic [1:0] next_duty_sel;
    logic       next_display_enable;

    // R10: only duty and enable bits are stored
    always_comb begin
        next_duty_sel       = duty_sel;
        next_display_enable = display_enable;
        if (bus_wr && ctrl_hit) begin
            next_duty_sel       = {bus_wdata[DUTY_HI_BIT], bus_wdata[DUTY_LO_BIT]};
            next_display_enable = bus_wdata[ENABLE_BIT];
        end
    end

    // R9: reset to 1/4 duty, display off
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            duty_sel       <= DUTY_RESET;
            display_enable <= ENABLE_RESET;
        end else begin
            duty_sel       <= next_duty_sel;
            display_enable <= next_display_enable;
        end
    end

    // read path; display memory reads as zero, bit 1 always zero
    // R2: no data from display memory
    always_comb begin
        bus_rdata = 4'h0;
        if (bus_rd && ctrl_hit) begin
            bus_rdata[DUTY_HI_BIT] = duty_sel[1];
            bus_rdata[DUTY_LO_BIT] = duty_sel[0];
            bus_rdata[ENABLE_BIT]  = display_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // common scan: slot timer and common counter
    logic [2:0]  com_count;
    logic [1:0]  com_idx;
    logic [31:0] slot_cnt;
    logic [1:0]  next_com_idx;
    logic [31:0] next_slot_cnt;

    // R4: duty code to number of commons
    always_comb begin
        case (sldc_duty_t'(duty_sel))
            SLDC_DUTY4: com_count = 3'h4;
            SLDC_DUTY3: com_count = 3'h3;
            SLDC_DUTY2: com_count = 3'h2;
            SLDC_DUTY1: com_count = 3'h1;
            default:    com_count = 3'h4;
        endcase
    end

    // R13: step through active commons each slot
    always_comb begin
        next_slot_cnt = slot_cnt + 32'h1;
        next_com_idx  = com_idx;
        if (slot_cnt >= 32'(SLOT_CYC - 1)) begin
            next_slot_cnt = 32'h0;
            next_com_idx  = ({1'b0, com_idx} + 3'h1 >= com_count) ? 2'h0 : com_idx + 2'h1;
        end else if ({1'b0, com_idx} >= com_count) begin
            // duty shrank under the scan; restart at common 0
            next_com_idx = 2'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            slot_cnt <= 32'h0;
            com_idx  <= 2'h0;
        end else begin
            slot_cnt <= next_slot_cnt;
            com_idx  <= next_com_idx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // segment selection through the build-time map
    logic [SEG_N-1:0] next_seg;
    genvar s;
    generate
        for (s = 0; s < SEG_N; s++) begin : g_seg
            logic [7:0] map_bit;
            assign map_bit = SEG_MAP[(s*COM_N + com_idx)*8 +: 8];
            // R7 R3: mapped bit lights the segment
            // R6 R8: unmapped common or display off forces dark
            // map values past the last memory bit mean an unconnected segment
            assign next_seg[s] = display_enable && ({1'b0, com_idx} < com_count)
                                 && (32'(map_bit) < DISP_WORDS * DATA_W)
                                 && disp_flat[map_bit];
        end
    endgenerate

    logic [COM_N-1:0] next_com;
    always_comb begin
        next_com = '0;
        // a common beyond the duty stays idle for the one cycle the scan needs to restart
        if (display_enable && ({1'b0, com_idx} < com_count)) next_com[com_idx] = 1'b1;
    end

    // registered panel outputs
    // R5: only active commons drive bits
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            seg_lit    <= '0;
            com_active <= '0;
            display_on <= 1'b0;
        end else begin
            seg_lit    <= next_seg;
            com_active <= next_com;
            display_on <= display_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    dark_when_off_a: assert property (!display_enable |=> seg_lit == '0) // R8
        else $error("segments lit while display off");
    ctrl_read_a: assert property (bus_rd && ctrl_hit |-> bus_rdata[1] == 1'b0) // R10
        else $error("unused control bit reads nonzero");
    disp_read_a: assert property (bus_rd && disp_hit |-> bus_rdata == 4'h0) // R2
        else $error("display memory returned data");
    ctrl_write_a: assert property (bus_wr && ctrl_hit |=> // R4
        duty_sel == $past({bus_wdata[3], bus_wdata[2]}) && display_enable == $past(bus_wdata[0]))
        else $error("control write not taken");
    com_range_a: assert property (duty_sel == $past(duty_sel) |-> {1'b0, com_idx} < com_count) // R5
        else $error("scan beyond duty");
    scan_idle_a: assert property ({1'b0, com_idx} >= com_count |=> seg_lit == '0 && com_active == '0) // R6
        else $error("common beyond duty driven");
    com_off_a: assert property (!display_enable |=> com_active == '0) // R8
        else $error("common active while display off");
    scan_step_a: assert property (slot_cnt == 32'(SLOT_CYC - 1) && com_count == 3'h4 // R13
        && duty_sel == $past(duty_sel) |=> com_idx == 2'($past(com_idx) + 2'h1))
        else $error("common did not advance");
    single_com_a: assert property (duty_sel == 2'h3 && $past(duty_sel) == 2'h3 |-> com_idx == 2'h0) // R6
        else $error("1/1 duty scanned other common");
    com_follow_a: assert property (display_enable && {1'b0, com_idx} < com_count |=> // R13
        com_active == (4'h1 << $past(com_idx)))
        else $error("common output mismatch");

    cov_enable_c: cover property (bus_wr && ctrl_hit && bus_wdata[0]);
    cov_wrap_c:   cover property (com_idx == 2'h3 ##1 com_idx == 2'h0);
    cov_lit_c:    cover property (seg_lit != '0);
    // duty shrunk under a running scan
    cov_shrink_c: cover property ({1'b0, com_idx} >= com_count);
endmodule
`default_nettype wire

// >>> tb/sldc_panel.sv
`timescale 1ns/1ns
`default_nettype none
module sldc_panel
    import sldc_pkg::*;
(
    // clock and capture control
    input  wire logic             ref_clk,
    input  wire logic             clr,
    // drive lines from the block
    input  wire logic [COM_N-1:0] com_active,
    input  wire logic [SEG_N-1:0] seg_lit,
    // what the glass showed
    output logic      [COM_N-1:0] seen,
    output logic      [SEG_N-1:0] img [COM_N],
    output logic                  bad
);
    // glass keeps the last pattern per common; two commons at once is a fault
    always @(posedge ref_clk) begin
        if (clr) begin
            seen <= '0;
            bad  <= 1'b0;
        end else if ($onehot(com_active)) begin
            for (int c = 0; c < COM_N; c++) begin
                if (com_active[c]) begin
                    img[c]  <= seg_lit;
                    seen[c] <= 1'b1;
                end
            end
        end else if (com_active != '0) begin
            bad <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> tb/segment_lcd_display_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module segment_lcd_display_control_tb
    import sldc_pkg::*;
;
    localparam int SLOT = 4;
    logic              ref_clk, rst_n, bus_wr, bus_rd, clr, display_on, bad;
    logic [ADDR_W-1:0] bus_addr;
    logic [DATA_W-1:0] bus_wdata, bus_rdata, rd_v;
    logic [COM_N-1:0]  com_active, seen;
    logic [SEG_N-1:0]  seg_lit, e;
    logic [SEG_N-1:0]  img [COM_N];
    logic [3:0]        mem [DISP_WORDS];
    int                fail_count, n_tests;

    // seg s, com c reads word 80H+s bit c; words A0H..AFH stay unmapped
    function automatic logic [SEG_N*COM_N*8-1:0] mk_map();
        logic [SEG_N*COM_N*8-1:0] m;
        for (int i = 0; i < SEG_N*COM_N; i++) m[i*8 +: 8] = 8'(i);
        return m;
    endfunction

    sldc_top #(.SLOT_CYC(SLOT), .SEG_MAP(mk_map())) u_sldc_top (
        .ref_clk(ref_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .com_active(com_active), .seg_lit(seg_lit), .display_on(display_on));
    sldc_panel u_sldc_panel (.ref_clk(ref_clk), .clr(clr), .com_active(com_active),
        .seg_lit(seg_lit), .seen(seen), .img(img), .bad(bad));

    ////////////////////////////////////////////////////////////////////////
    // free-running clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe, released a full cycle later
    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        @(negedge ref_clk);
        bus_addr = a; bus_wdata = d; bus_wr = 1'b1;
        @(negedge ref_clk);
        bus_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge ref_clk);
        bus_addr = a; bus_rd = 1'b1;
        // taken half a cycle after the edge, where the read data has settled
        @(negedge ref_clk);
        rd_v = bus_rdata;
        bus_rd = 1'b0;
    endtask

    task automatic final_report();
        if (fail_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_ctrl();
        rd(CTRL_ADDR);
        chk(rd_v, 0);
        chk(display_on, 0);
        wr(CTRL_ADDR, 4'hF);
        rd(CTRL_ADDR);
        chk(rd_v, 4'hD);
        wr(CTRL_ADDR, 4'h0);
    endtask

    // whole memory written before the display is enabled
    task automatic test_mem();
        for (int w = 0; w < DISP_WORDS; w++) begin
            mem[w] = (w >= 32) ? 4'hF : 4'(w * 5 + 3);
            wr(DISP_FIRST + 8'(w), mem[w]);
        end
        rd(DISP_FIRST);
        chk(rd_v, 0);
        rd(DISP_LAST);
        chk(rd_v, 0);
    endtask

    // every duty code: scan the right commons, one at a time, right pattern
    task automatic test_scan();
        for (int d = 0; d < 4; d++) begin
            wr(CTRL_ADDR, {2'(d), 2'b01});
            @(negedge ref_clk) clr = 1'b1;
            @(negedge ref_clk) clr = 1'b0;
            repeat (SLOT * COM_N * 2 + 4) @(negedge ref_clk);
            chk(seen, (1 << (4 - d)) - 1);
            chk(bad, 0);
            chk(display_on, 1);
            for (int c = 0; c < 4 - d; c++) begin
                for (int s = 0; s < SEG_N; s++) e[s] = mem[s][c];
                chk(img[c], e);
            end
        end
    endtask

    // reset in mid-run with the display lit: control and panel drop back
    task automatic test_reset();
        @(negedge ref_clk) rst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        chk(seg_lit, 0);
        chk(com_active, 0);
        chk(display_on, 0);
        rd(CTRL_ADDR);
        chk(rd_v, 0);
    endtask

    task automatic test_off();
        wr(CTRL_ADDR, 4'h4);
        repeat (2) @(negedge ref_clk);
        chk(seg_lit, 0);
        chk(com_active, 0);
        chk(display_on, 0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence: 20-cycle reset, then the scenarios
    initial begin
        fail_count = 0; n_tests = 0; clr = 1'b0;
        rst_n = 1'b0; bus_wr = 1'b0; bus_rd = 1'b0;
        bus_addr = '0; bus_wdata = '0;
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
        // memory is filled before any write that turns the display on
        test_mem();
        test_ctrl();
        test_scan();
        test_reset();
        test_off();
        final_report();
    end

    // watchdog: the run needs well under a thousand cycles
    initial begin
        #1000000;
        fail_count++;
        final_report();
    end
endmodule
`default_nettype wire
